// ---- rtl/scg_pkg.sv ----
// Package of constants for the sink current generator control block
package scg_pkg;
  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] SCG_OFS_CONTROL = 12'h000;
  localparam logic [11:0] SCG_OFS_LEVEL0 = 12'h004;
  localparam logic [11:0] SCG_OFS_LEVEL1 = 12'h008;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SCG_BIT_MASTER = 7;
  localparam int SCG_BIT_OUT1 = 1;
  localparam int SCG_BIT_OUT0 = 0;
  localparam int SCG_CODE_W = 5;
  localparam logic [4:0] SCG_CODE_RST = 5'h00;
  localparam logic SCG_EN_RST = 1'b0;
  localparam logic SCG_FLOAT_RST = 1'b1;
  // ****************************************************************
  // Current law in mA
  // ****************************************************************
  localparam logic [9:0] SCG_BASE_MA = 10'h032;
  localparam logic [9:0] SCG_STEP0_MA = 10'h00a;
  localparam logic [9:0] SCG_STEP1_MA = 10'h005;
endpackage

// ---- rtl/scg_sink_chan.sv ----
// One sink output channel: gating and current setpoint
`timescale 1ns/1ns
module scg_sink_chan #(
  parameter logic [9:0] STEP_MA = 10'h00a
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic master_en_i,
  input wire logic out_en_i,
  input wire logic [4:0] code_i,
  output logic sink_on_o,
  output logic node_float_o,
  output logic [4:0] level_o,
  output logic [9:0] current_ma_o
);
  logic on_d, on_q, float_d, float_q;
  logic [4:0] lvl_d, lvl_q;
  logic [9:0] ma_d, ma_q;

  always_comb begin
    on_d = master_en_i & out_en_i;
    float_d = ~master_en_i;
    lvl_d = master_en_i ? code_i : 5'h00;
    // Setpoint reads zero whenever the sink is not drawing
    ma_d = on_d ? 10'(scg_pkg::SCG_BASE_MA + STEP_MA * {5'h00, code_i})
                : 10'h000;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      on_q <= 1'b0;
      float_q <= scg_pkg::SCG_FLOAT_RST;
      lvl_q <= 5'h00;
      ma_q <= 10'h000;
    end else begin
      on_q <= on_d;
      float_q <= float_d;
      lvl_q <= lvl_d;
      ma_q <= ma_d;
    end
  end

  assign sink_on_o = on_q;
  assign node_float_o = float_q;
  assign level_o = lvl_q;
  assign current_ma_o = ma_q;
endmodule // scg_sink_chan

// ---- rtl/scg_ctrl.sv ----
// APB register bank and control decode for the sink current generator
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
module scg_ctrl (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sink_out0_pin_on_o,
  output logic sink_out1_pin_on_o,
  output logic sink_out0_float_o,
  output logic sink_out1_float_o,
  output logic [4:0] sink0_level_o,
  output logic [4:0] sink1_level_o,
  output logic [9:0] sink0_current_ma_o,
  output logic [9:0] sink1_current_ma_o
);
  // ****************************************************************
  // Bus decode
  // ****************************************************************
  localparam int NCH = 2;

  logic setup;
  logic access;
  logic wr;
  logic hit;
  logic hit_ctl;
  logic [NCH-1:0] hit_lvl;
  logic lvl_idx;
  logic ready_d;
  logic ready_q;
  logic err_d;
  logic err_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // Setup cycle arms the answer; the access cycle carries it
  assign setup = psel & ~penable;
  assign access = psel & penable & ready_q;
  // A write without its low byte lane is dropped whole
  assign wr = access & pwrite & pstrb[0];
  assign hit = hit_ctl | (|hit_lvl);

  // Unmapped offsets fall through and earn the error answer
  always_comb begin
    hit_ctl = 1'b0;
    hit_lvl = 2'h0;
    lvl_idx = 1'b0;
    if (paddr == scg_pkg::SCG_OFS_CONTROL) begin
      hit_ctl = 1'b1;
    end else if (paddr == scg_pkg::SCG_OFS_LEVEL0) begin
      hit_lvl = 2'h1;
      lvl_idx = 1'b0;
    end else if (paddr == scg_pkg::SCG_OFS_LEVEL1) begin
      hit_lvl = 2'h2;
      lvl_idx = 1'b1;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  logic master_d;
  logic master_q;
  logic out1_d;
  logic out1_q;
  logic out0_d;
  logic out0_q;

  // A control write replaces all three bits at once
  always_comb begin
    master_d = master_q;
    out1_d = out1_q;
    out0_d = out0_q;
    if (wr && hit_ctl) begin
      master_d = pwdata[scg_pkg::SCG_BIT_MASTER];
      out1_d = pwdata[scg_pkg::SCG_BIT_OUT1];
      out0_d = pwdata[scg_pkg::SCG_BIT_OUT0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      master_q <= scg_pkg::SCG_EN_RST;
      out1_q <= scg_pkg::SCG_EN_RST;
      out0_q <= scg_pkg::SCG_EN_RST;
    end else begin
      master_q <= master_d;
      out1_q <= out1_d;
      out0_q <= out0_d;
    end
  end

  // ****************************************************************
  // Level-code registers
  // ****************************************************************
  // One entry per sink, picked by the decoded index
  logic [4:0] code_d [NCH];
  logic [4:0] code_q [NCH];

  always_comb begin
    for (int ch = 0; ch < NCH; ch++) begin
      code_d[ch] = code_q[ch];
    end
    // Bits 7 to 5 of the word have no storage and are dropped
    if (wr && (|hit_lvl)) begin
      code_d[lvl_idx] = pwdata[scg_pkg::SCG_CODE_W-1:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    for (int ch = 0; ch < NCH; ch++) begin
      if (srst_i) begin
        code_q[ch] <= scg_pkg::SCG_CODE_RST;
      end else begin
        code_q[ch] <= code_d[ch];
      end
    end
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // Zero wait state: pready rises in the first access cycle
  always_comb begin
    ready_d = setup;
    // Only a setup cycle on an unmapped offset errors
    err_d = setup & ~hit;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ready_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ready_q <= ready_d;
      err_q <= err_d;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Read data stands for the one access cycle only
  always_comb begin
    // In a control read, bits 6 to 2 and every upper bit are never set, so they read zero
    rdata_d = 32'h0000_0000;
    if (setup && !pwrite) begin
      if (hit_ctl) begin
        rdata_d[scg_pkg::SCG_BIT_MASTER] = master_q;
        rdata_d[scg_pkg::SCG_BIT_OUT1] = out1_q;
        rdata_d[scg_pkg::SCG_BIT_OUT0] = out0_q;
      end else if (|hit_lvl) begin
        rdata_d[scg_pkg::SCG_CODE_W-1:0] = code_q[lvl_idx];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Bus outputs leave straight from their flops
  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = err_q;

  // ****************************************************************
  // Sink channels
  // ****************************************************************
  // Each channel registers its own pins, so they trail the bank by
  // one cycle; this keeps every pin glitch free
  logic chan_en [NCH];
  logic chan_on [NCH];
  logic chan_float [NCH];
  logic [4:0] chan_level [NCH];
  logic [9:0] chan_ma [NCH];

  always_comb begin
    chan_en[0] = out0_q;
    chan_en[1] = out1_q;
  end

  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    // Output 0 steps by 10 mA, output 1 by 5 mA
    localparam logic [9:0] STEP = (ch == 0) ? scg_pkg::SCG_STEP0_MA
        : scg_pkg::SCG_STEP1_MA;
    scg_sink_chan #(.STEP_MA(STEP)) u_chan (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .master_en_i(master_q),
      .out_en_i(chan_en[ch]),
      .code_i(code_q[ch]),
      .sink_on_o(chan_on[ch]),
      .node_float_o(chan_float[ch]),
      .level_o(chan_level[ch]),
      .current_ma_o(chan_ma[ch])
    );
  end

  // ****************************************************************
  // Pin outputs
  // ****************************************************************
  // Channel outputs leave straight from the channel flops
  assign sink_out0_pin_on_o = chan_on[0];
  assign sink_out1_pin_on_o = chan_on[1];
  assign sink_out0_float_o = chan_float[0];
  assign sink_out1_float_o = chan_float[1];

  assign sink0_level_o = chan_level[0];
  assign sink1_level_o = chan_level[1];
  assign sink0_current_ma_o = chan_ma[0];
  assign sink1_current_ma_o = chan_ma[1];
endmodule // scg_ctrl

// ---- dv/scg_ctrl_checker.sv ----
// Port assertions for the sink generator register bank
`timescale 1ns/1ns
module scg_ctrl_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic sink_out0_pin_on_o,
  input wire logic sink_out1_pin_on_o,
  input wire logic sink_out0_float_o,
  input wire logic sink_out1_float_o,
  input wire logic [4:0] sink0_level_o,
  input wire logic [4:0] sink1_level_o,
  input wire logic [9:0] sink0_current_ma_o,
  input wire logic [9:0] sink1_current_ma_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Write lands at the access edge, channel outputs one edge later
  sequence s_ctl_wr;
    pready && pwrite && paddr == 12'h000;
  endsequence
  a_wr_master: assert property (s_ctl_wr |-> ##2
    sink_out0_float_o == !$past(pwdata[7], 2)) else $error("master");
  a_wr_out0: assert property (s_ctl_wr |-> ##2
    sink_out0_pin_on_o == ($past(pwdata[7], 2) && $past(pwdata[0], 2)))
    else $error("out0");
  a_wr_out1: assert property (s_ctl_wr |-> ##2
    sink_out1_pin_on_o == ($past(pwdata[7], 2) && $past(pwdata[1], 2)))
    else $error("out1");
  a_off_zero: assert property (sink_out0_float_o |->
    sink_out1_float_o && !sink_out0_pin_on_o && !sink_out1_pin_on_o &&
    sink0_current_ma_o == 10'h000 && sink1_current_ma_o == 10'h000 &&
    sink0_level_o == 5'h00 && sink1_level_o == 5'h00)
    else $error("off");
  a_cur0_law: assert property (sink_out0_pin_on_o |->
    sink0_current_ma_o == 10'h032 + 10'h00a * sink0_level_o)
    else $error("cur0");
  a_cur1_law: assert property (sink_out1_pin_on_o |->
    sink1_current_ma_o == 10'h032 + 10'h005 * sink1_level_o)
    else $error("cur1");
  a_rd_zero: assert property (
    pready && !pwrite && paddr == 12'h000 |->
    prdata[31:8] == 24'h000000 && prdata[6:2] == 5'h00) else $error("rd");
  a_rst_clear: assert property ($fell(srst_i) |->
    sink_out0_float_o && sink_out1_float_o && !pready) else $error("rst");
endmodule // scg_ctrl_checker
bind scg_ctrl scg_ctrl_checker scg_ctrl_checker_i (.core_clk_i, .srst_i,
  .pwrite, .pready, .paddr, .pwdata, .prdata, .sink_out0_pin_on_o,
  .sink_out1_pin_on_o, .sink_out0_float_o, .sink_out1_float_o,
  .sink0_level_o, .sink1_level_o, .sink0_current_ma_o, .sink1_current_ma_o);

// ---- dv/tb_scg_ctrl.sv ----
// Self-checking bench for the sink generator register bank
`timescale 1ns/1ns
module tb_scg_ctrl;
  logic core_clk_i = 1'b0, srst_i = 1'b1, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic sink_out0_pin_on_o, sink_out1_pin_on_o;
  logic sink_out0_float_o, sink_out1_float_o;
  logic [4:0] sink0_level_o, sink1_level_o;
  logic [9:0] sink0_current_ma_o, sink1_current_ma_o;
  int miscompares = 0, n_checks = 0, cyc = 0;
  scg_ctrl scg_ctrl_i (.core_clk_i, .srst_i, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr,
    .sink_out0_pin_on_o, .sink_out1_pin_on_o, .sink_out0_float_o,
    .sink_out1_float_o, .sink0_level_o, .sink1_level_o,
    .sink0_current_ma_o, .sink1_current_ma_o);
  always #2 core_clk_i = ~core_clk_i;
  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Released a full edge before the next setup, so no double drive
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge core_clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic outs(input logic [7:0] c, input logic [4:0] a, b);
    logic [9:0] e0, e1;
    // Setpoint law while drawing, zero otherwise
    e0 = (c[7] & c[0]) ? 10'h032 + 10'h00a * a : 10'h000;
    e1 = (c[7] & c[1]) ? 10'h032 + 10'h005 * b : 10'h000;
    repeat (2) @(posedge core_clk_i);
    chk({sink_out1_float_o, sink_out0_float_o}, {2{!c[7]}});
    chk(sink_out0_pin_on_o, c[7] & c[0]);
    chk(sink_out1_pin_on_o, c[7] & c[1]);
    chk(sink0_level_o, c[7] ? a : 5'h00);
    chk(sink1_level_o, c[7] ? b : 5'h00);
    chk(sink0_current_ma_o, e0);
    chk(sink1_current_ma_o, e1);
  endtask
  initial begin
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h000, 32'hffff_ffff);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h83);
    apb(1'b1, 12'h00c, 32'hff);
    chk(er, 1'b1);
    apb(1'b1, 12'h004, 32'hf3);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h13);
    apb(1'b1, 12'h008, 32'he9);
    // Junk in the unused control bits must not disturb the decode
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, {24'h0, i[2], 5'h15, i[1:0]});
      outs({i[2], 5'h0, i[1:0]}, 5'h13, 5'h09);
    end
    for (int k = 0; k < 32; k++) begin
      apb(1'b1, 12'h004, 32'(k));
      apb(1'b1, 12'h008, 32'(31 - k));
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, 32'(31 - k));
      outs(8'h83, 5'(k), 5'(31 - k));
    end
    // Reset in mid-run must drop the pins and clear every register
    srst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    srst_i <= 1'b0;
    outs(8'h00, 5'h00, 5'h00);
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    finish_test();
  end
endmodule // tb_scg_ctrl
